//--- seg_map.vh
// Functional notes
// R1: A pointer is a 16-bit selector plus 16-bit offset giving one address.
// R2: Real mode address is selector shifted left four plus offset, 20 bits.
// R3: A directly supplied physical address may be up to 24 bits wide.
// R4: Protected mode address is the indexed descriptor base plus the offset.
// R5: Local table base comes from the global descriptor named by the local pointer.
// R6: An access-supplied local selector overrides the held local table pointer.
// R7: Real mode 24-bit accesses have the upper four bits forced to zero.
// R8: Reset leaves real mode; first fetch address is 0fffff0.
// R9: Writing protect enable to 1 in the status word enters protected mode.
// R10: Four privilege levels 0 to 3, 0 most privileged; one current level.
// R11: Data access allowed only when descriptor level >= effective level.
// R12: Conforming segments are readable from any level; current level unchanged.
// R13: Non-conforming executable segment needs descriptor level equal current level.
// R14: Requested level replaces current level when numerically larger.
// R15: Descriptor level from access field; current level from code selector.
// R16: Direct transfer needs target descriptor level equal current level.
// R17: Call gate descriptor level must be >= current level.
// R18: Call gate target descriptor level must be <= current level.
// R19: I/O privilege level sets the current level needed for I/O instructions.
// R20: Requester presents no absolute address when translate and check are both set.
// R21: Selector holds 14 address bits and two requested-level bits.
// R22: Table indicator picks global or local table; 13 bits index it.
// R23: Table index times eight gives the descriptor byte offset.
// R24: Any failed check pulses a violation flag for one cycle and drops the access.
// R25: Reset clears protect enable, current level 0 and local table pointer.
//
// Purpose: Constants for the segment translate and protect unit
// Assumes: Descriptor words are fetched through a simple read port
// Notes:   Definitions only
`ifndef SEG_MAP_VH
`define SEG_MAP_VH
// Register port offsets
`define REG_MODE_OFF       4'h0
`define REG_LOCAL_PTR_OFF  4'h1
`define REG_GLOBAL_BASE_OFF 4'h2
`define REG_CODE_SEL_OFF   4'h3
`define REG_IOPL_OFF       4'h4
`define REG_STATUS_OFF     4'h5
`define REG_LOCAL_BASE_OFF 4'h6
// Field positions
`define MODE_PE_BIT        0
`define SEL_TBL_BIT        2
`define AR_LVL_LO          5
`define AR_CONFORM_BIT     2
`define AR_EXEC_BIT        3
// Reset values
`define RESET_FETCH_ADDR   24'hfffff0
`define RESET_LOCAL_PTR    16'h0000
`define RESET_LEVEL        2'h0
`define RESET_IOPL         2'h0
// Access kinds
`define KIND_READ          3'h0
`define KIND_WRITE         3'h1
`define KIND_JUMP          3'h2
`define KIND_GATE          3'h3
`define KIND_IO            3'h4
`define KIND_ABS           3'h5
`endif

//--- desc_mem.v
// Purpose: Descriptor table storage, 16-bit words with registered read
// Assumes: One read and one write port on clk_in
// Notes:   Each descriptor spans four words (eight bytes)
`timescale 1ns/1ps
module desc_mem #(
   parameter AW = 10
) (
   // Clock
   input  wire          clk_in,
   // Write port
   input  wire          wr_en_in,
   input  wire [AW-1:0] wr_addr_in,
   input  wire [15:0]   wr_data_in,
   // Read port
   input  wire [AW-1:0] rd_addr_in,
   output reg  [15:0]   rd_data_out
);
   reg [15:0] mem [0:(1<<AW)-1];

   // Registered read keeps the fetch path timing simple
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule // desc_mem

//--- seg_translate_protect.v
// Purpose: Segment address translation and privilege checking
// Assumes: Requests held stable until done_out; one request in flight
// Notes:   Descriptor table lives in desc_mem, loaded via table write port
`timescale 1ns/1ps
`include "seg_map.vh"
module seg_translate_protect #(
   parameter MAW = 10
) (
   // Clock and reset
   input  wire            clk_in,
   input  wire            sys_rst_in,
   // Register port
   input  wire [3:0]      reg_addr_in,
   input  wire [15:0]     reg_wdata_in,
   input  wire            reg_wr_in,
   input  wire            reg_rd_in,
   output reg  [15:0]     reg_rdata_out,
   // Descriptor table load
   input  wire            tbl_wr_in,
   input  wire [MAW-1:0]  tbl_addr_in,
   input  wire [15:0]     tbl_wdata_in,
   // Mode flags
   input  wire            translation_select_flag_in,
   input  wire            protection_check_flag_in,
   // Access request
   input  wire            req_in,
   input  wire [2:0]      req_kind_in,
   input  wire [15:0]     req_sel_in,
   input  wire [15:0]     req_off_in,
   input  wire [23:0]     req_abs_in,
   input  wire            req_loc_ovr_in,
   input  wire [15:0]     req_loc_sel_in,
   input  wire            req_wide_in,
   // Result
   output reg             done_out,
   output reg  [23:0]     phys_addr_out,
   output reg             violation_out,
   output reg             protect_mode_out
);
   // States
   localparam ST_IDLE  = 3'd0;
   localparam ST_LOC0  = 3'd1;
   localparam ST_LOC1  = 3'd2;
   localparam ST_SEG0  = 3'd3;
   localparam ST_SEG1  = 3'd4;
   localparam ST_SEG2  = 3'd5;
   localparam ST_CHECK = 3'd6;
   localparam ST_DONE  = 3'd7;

   reg  [2:0]     state_reg;
   reg  [15:0]    machine_status_word_reg;
   reg  [15:0]    local_table_pointer_reg;
   reg  [23:0]    global_table_pointer_reg;
   reg  [15:0]    code_sel_reg;
   reg  [1:0]     iopl_reg;
   reg  [23:0]    local_base_reg;
   reg  [23:0]    seg_base_reg;
   reg  [7:0]     access_rights_reg;
   reg  [MAW-1:0] rd_addr_reg;
   reg            last_viol_reg;
   wire [15:0]    rd_data;
   wire [MAW-1:0] rd_addr_inc = rd_addr_reg + {{(MAW-1){1'b0}}, 1'b1};

   wire [1:0] current_priv_level = code_sel_reg[1:0];        // [R15]
   wire       pe = machine_status_word_reg[`MODE_PE_BIT];

   ////////////////////////////////////////////////////////////////
   // Helpers
   // Word index of a descriptor's base low word
   function [MAW-1:0] desc_word;
      input [23:0] base;
      input [15:0] sel;
      reg   [23:0] byte_addr;
      begin
         byte_addr = base + {8'h00, sel[15:3], 3'b010};       // [R22] [R23]
         desc_word = byte_addr[MAW:1];
      end
   endfunction

   // Larger of two levels, the weaker privilege
   function [1:0] max_lvl;
      input [1:0] a;
      input [1:0] b;
      begin
         max_lvl = (a > b) ? a : b;
      end
   endfunction

   // Real mode pointer form, at most 20 bits, top nibble zero
   function [23:0] real_addr;
      input [15:0] sel;
      input [15:0] off;
      reg   [19:0] sum;
      begin
         sum = {sel, 4'h0} + {4'h0, off};                      // [R1] [R2]
         real_addr = {4'h0, sum};
      end
   endfunction

   desc_mem #(.AW(MAW)) u_desc_mem (
      .clk_in      (clk_in),
      .wr_en_in    (tbl_wr_in),
      .wr_addr_in  (tbl_addr_in),
      .wr_data_in  (tbl_wdata_in),
      .rd_addr_in  (rd_addr_reg),
      .rd_data_out (rd_data)
   );

   ////////////////////////////////////////////////////////////////
   // Privilege decision, combinational from fetched access rights
   wire [1:0] dlvl       = access_rights_reg[`AR_LVL_LO+1:`AR_LVL_LO]; // [R15]
   wire       conforming = access_rights_reg[`AR_CONFORM_BIT];
   wire       executable = access_rights_reg[`AR_EXEC_BIT];
   wire [1:0] eff_lvl    = max_lvl(current_priv_level, req_sel_in[1:0]); // [R14] [R21]
   wire [1:0] gate_tgt   = req_off_in[1:0];
   reg        allow;

   always @* begin
      allow = 1'b0;
      case (req_kind_in)
         `KIND_READ: begin
            if (executable && conforming)
               allow = 1'b1;                                   // [R12]
            else if (executable)
               allow = (dlvl == current_priv_level);           // [R13]
            else
               allow = (dlvl >= eff_lvl);                      // [R11]
         end
         `KIND_WRITE: begin
            if (executable)
               allow = (dlvl == current_priv_level);           // [R13]
            else
               allow = (dlvl >= eff_lvl);                      // [R11]
         end
         `KIND_JUMP: allow = (dlvl == current_priv_level);     // [R16]
         `KIND_GATE: allow = (dlvl >= current_priv_level) &&   // [R17]
                             (gate_tgt <= current_priv_level); // [R18]
         default:    allow = 1'b0;
      endcase
   end

   // Descriptor checks need protection on and the check flag set
   wire checking = pe && protection_check_flag_in;
   // Absolute address refused while translating and checking
   wire abs_bad  = translation_select_flag_in && protection_check_flag_in; // [R20]
   wire io_ok    = !pe || (current_priv_level <= iopl_reg);   // [R19] [R10]

   ////////////////////////////////////////////////////////////////
   // Request sequencer
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg         <= ST_IDLE;
         done_out          <= 1'b0;
         violation_out     <= 1'b0;
         phys_addr_out     <= `RESET_FETCH_ADDR;               // [R8]
         seg_base_reg      <= 24'h000000;
         access_rights_reg <= 8'h00;
         local_base_reg    <= 24'h000000;
         rd_addr_reg       <= {MAW{1'b0}};
         last_viol_reg     <= 1'b0;
      end else begin
         done_out      <= 1'b0;
         violation_out <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (req_in) begin
                  if (req_kind_in == `KIND_ABS) begin
                     done_out <= 1'b1;
                     if (abs_bad) begin
                        violation_out <= 1'b1;                 // [R24]
                        last_viol_reg <= 1'b1;
                     end else if (!pe || req_wide_in == 1'b0) begin
                        phys_addr_out <= {4'h0, req_abs_in[19:0]}; // [R7]
                        last_viol_reg <= 1'b0;
                     end else begin
                        phys_addr_out <= req_abs_in;           // [R3]
                        last_viol_reg <= 1'b0;
                     end
                  end else if (req_kind_in == `KIND_IO) begin
                     done_out      <= 1'b1;
                     violation_out <= !io_ok;                  // [R24]
                     last_viol_reg <= !io_ok;
                  end else if (!translation_select_flag_in) begin
                     phys_addr_out <= real_addr(req_sel_in, req_off_in); // [R2]
                     done_out      <= 1'b1;
                     last_viol_reg <= 1'b0;
                  end else if (req_sel_in[`SEL_TBL_BIT]) begin
                     // Local table: fetch its descriptor from the global table
                     rd_addr_reg <= desc_word(global_table_pointer_reg,
                        req_loc_ovr_in ? req_loc_sel_in            // [R6]
                                       : local_table_pointer_reg); // [R5]
                     state_reg   <= ST_LOC0;
                  end else begin
                     rd_addr_reg <= desc_word(global_table_pointer_reg, req_sel_in); // [R4]
                     state_reg   <= ST_SEG0;
                  end
               end
            end
            ST_LOC0: begin
               // Base low word lands next cycle
               rd_addr_reg <= rd_addr_inc;
               state_reg   <= ST_LOC1;
            end
            ST_LOC1: begin
               local_base_reg[15:0] <= rd_data;
               state_reg   <= ST_SEG0;
            end
            ST_SEG0: begin
               if (req_sel_in[`SEL_TBL_BIT]) begin
                  // Local base complete
                  local_base_reg[23:16] <= rd_data[7:0];
                  rd_addr_reg <= desc_word({rd_data[7:0], local_base_reg[15:0]}, req_sel_in);
                  state_reg   <= ST_SEG1;
               end else begin
                  rd_addr_reg <= rd_addr_inc;
                  state_reg   <= ST_SEG2;
               end
            end
            ST_SEG1: begin
               rd_addr_reg <= rd_addr_inc;
               state_reg   <= ST_SEG2;
            end
            ST_SEG2: begin
               seg_base_reg[15:0] <= rd_data;
               state_reg <= ST_CHECK;
            end
            ST_CHECK: begin
               seg_base_reg[23:16] <= rd_data[7:0];
               access_rights_reg   <= rd_data[15:8];
               state_reg <= ST_DONE;
            end
            ST_DONE: begin
               // Final: base plus offset, or refuse
               done_out <= 1'b1;
               state_reg <= ST_IDLE;
               if (checking && !allow) begin
                  violation_out <= 1'b1;                       // [R24]
                  last_viol_reg <= 1'b1;
               end else begin
                  phys_addr_out <= seg_base_reg + {8'h00, req_off_in}; // [R4]
                  last_viol_reg <= 1'b0;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Register port; a violation changes no register except the status bit last_viol_reg
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         machine_status_word_reg  <= 16'h0000;                 // [R25] [R8]
         local_table_pointer_reg  <= `RESET_LOCAL_PTR;         // [R25]
         global_table_pointer_reg <= 24'h000000;
         code_sel_reg             <= {14'h0000, `RESET_LEVEL}; // [R25]
         iopl_reg                 <= `RESET_IOPL;
         reg_rdata_out            <= 16'h0000;
         protect_mode_out         <= 1'b0;
      end else begin
         protect_mode_out <= pe;
         if (reg_wr_in) begin
            case (reg_addr_in)
               `REG_MODE_OFF: begin
                  // Once set, only reset leaves protected mode
                  machine_status_word_reg <= reg_wdata_in |
                     {15'h0000, pe};                           // [R9]
                  protect_mode_out <= pe | reg_wdata_in[`MODE_PE_BIT]; // [R9]
               end
               `REG_LOCAL_PTR_OFF:   local_table_pointer_reg <= reg_wdata_in;
               `REG_GLOBAL_BASE_OFF: global_table_pointer_reg <= {8'h00, reg_wdata_in};
               `REG_CODE_SEL_OFF:    code_sel_reg <= reg_wdata_in;
               `REG_IOPL_OFF:        iopl_reg <= reg_wdata_in[1:0];
               default: ;
            endcase
         end
         reg_rdata_out <= 16'h0000;
         if (reg_rd_in) begin
            case (reg_addr_in)
               `REG_MODE_OFF:        reg_rdata_out <= machine_status_word_reg;
               `REG_LOCAL_PTR_OFF:   reg_rdata_out <= local_table_pointer_reg;
               `REG_GLOBAL_BASE_OFF: reg_rdata_out <= global_table_pointer_reg[15:0];
               `REG_CODE_SEL_OFF:    reg_rdata_out <= code_sel_reg;
               `REG_IOPL_OFF:        reg_rdata_out <= {14'h0000, iopl_reg};
               `REG_STATUS_OFF:      reg_rdata_out <= {12'h000, last_viol_reg,
                                                       state_reg};
               `REG_LOCAL_BASE_OFF:  reg_rdata_out <= local_base_reg[15:0];
               default:              reg_rdata_out <= 16'h0000;
            endcase
         end
      end
   end
endmodule // seg_translate_protect

//--- seg_stp_properties.sv
// Purpose: Port-level checks for the segment translate and protect unit
// Assumes: Requester holds a request until done_out, one in flight
// Notes:   Bound after the module
`timescale 1ns/1ps
module seg_stp_checker (
   // Clock and reset
   input wire        clk_in,
   input wire        sys_rst_in,
   // Register port
   input wire [3:0]  reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire        reg_wr_in,
   // Request side
   input wire        translation_select_flag_in,
   input wire        req_in,
   input wire [2:0]  req_kind_in,
   input wire [15:0] req_sel_in,
   input wire [15:0] req_off_in,
   input wire [23:0] req_abs_in,
   input wire        req_wide_in,
   input wire        req_loc_ovr_in,
   // Results
   input wire        done_out,
   input wire [23:0] phys_addr_out,
   input wire        violation_out,
   input wire        protect_mode_out
);
   // Real mode sum, 20 bits
   wire [19:0] real_sum = {req_sel_in, 4'h0} + {4'h0, req_off_in};
   wire        real_req = req_in && !translation_select_flag_in && !protect_mode_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////////////////////////////////////////
   chk_done_pulse: assert property (done_out |=> !done_out)
      else $error("done_out longer than one cycle");
   chk_viol_done: assert property (violation_out |-> done_out)
      else $error("violation without done");
   chk_viol_keep: assert property (violation_out |-> $stable(phys_addr_out))
      else $error("address moved on a violation");
   chk_real_map: assert property (real_req && req_kind_in == 3'h0 |=>
      done_out && phys_addr_out == {4'h0, $past(real_sum)})
      else $error("real mode address wrong");
   chk_abs_real: assert property (real_req && req_kind_in == 3'h5 && req_wide_in |=>
      done_out && phys_addr_out == {4'h0, req_abs_in[19:0]})
      else $error("real mode wide address not cut");
   chk_reset_vec: assert property ($fell(sys_rst_in) |->
      phys_addr_out == 24'hfffff0 && !protect_mode_out)
      else $error("reset state wrong");
   chk_pe_cause: assert property ($rose(protect_mode_out) |->
      $past(reg_wr_in) && $past(reg_addr_in) == 4'h0 && $past(reg_wdata_in[0]))
      else $error("protected mode without write");
   chk_pe_write: assert property (reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[0]
      |=> protect_mode_out)
      else $error("protect enable write ignored");
   chk_done_bound: assert property (req_in && !done_out |-> ##[1:16] done_out)
      else $error("request not answered");
   // Main scenarios seen
   cov_viol: cover property (violation_out);
   cov_prot: cover property (done_out && protect_mode_out && !violation_out);
   cov_ovr: cover property (req_in && req_loc_ovr_in);
endmodule // seg_stp_checker

bind seg_translate_protect seg_stp_checker u_chk (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .translation_select_flag_in(translation_select_flag_in), .req_in(req_in),
   .req_kind_in(req_kind_in), .req_sel_in(req_sel_in), .req_off_in(req_off_in),
   .req_abs_in(req_abs_in), .req_wide_in(req_wide_in), .req_loc_ovr_in(req_loc_ovr_in),
   .done_out(done_out), .phys_addr_out(phys_addr_out), .violation_out(violation_out),
   .protect_mode_out(protect_mode_out));

//--- seg_requester.sv
// Purpose: Model of the core or debug logic that issues accesses
// Assumes: One request at a time; req_out pulses for one cycle, fields held until done
// Notes:   Released selector, offset, address and local selector fields show their inverse
`timescale 1ns/1ps
module seg_requester (
   // Clock, mode flags and done
   input wire        clk_in,
   input wire        tsf_in,
   input wire        pcf_in,
   input wire        done_in,
   // Request fields, 16-bit selector and offset
   output reg        req_out = 1'b0,
   output reg [2:0]  kind_out = 3'h0,
   output reg [15:0] sel_out = 16'h0000,
   output reg [15:0] off_out = 16'h0000,
   output reg [23:0] abs_out = 24'h000000,
   output reg        ovr_out = 1'b0,
   output reg [15:0] loc_sel_out = 16'h0000,
   output reg        wide_out = 1'b0
);
   // One access; ok low on timeout
   task issue(input [2:0] k, input [15:0] s, input [15:0] o, input [23:0] a,
              input ov, input [15:0] ls, input w, output ok);
      integer n;
      begin
         ok = 1'b1;
         // No absolute form under translate and check
         if (k != 3'h5 || !(tsf_in && pcf_in)) begin
            @(posedge clk_in);
            req_out <= 1'b1;
            // Local selector rides along
            {kind_out, sel_out, off_out, abs_out, ovr_out, loc_sel_out, wide_out}
               <= {k, s, o, a, ov, ls, w};
            @(posedge clk_in);
            req_out <= 1'b0;
            n = 0;
            @(negedge clk_in);
            while (done_in !== 1'b1 && n < 40) begin
               n = n + 1;
               @(negedge clk_in);
            end
            ok = (n < 40);
            @(posedge clk_in);
            {sel_out, off_out, abs_out, loc_sel_out} <= ~{s, o, a, ls};
         end
      end
   endtask
endmodule // seg_requester

//--- tb.sv
// Purpose: Self-checking bench for the segment translate and protect unit
// Assumes: Global table at byte 0, two local tables, I/O level 1
// Notes:   Expected results queue up; a monitor compares them in order
`timescale 1ns/1ps
module tb;
   reg          clk_in = 1'b0;
   reg          sys_rst_in = 1'b1;
   reg  [3:0]   reg_addr = 4'h0;
   reg  [15:0]  reg_wdata = 16'h0000;
   reg          reg_wr = 1'b0;
   reg          reg_rd = 1'b0;
   reg          tbl_wr = 1'b0;
   reg  [9:0]   tbl_addr = 10'h000;
   reg  [15:0]  tbl_wdata = 16'h0000;
   reg          tsf = 1'b0;
   reg          pcf = 1'b0;
   wire         req, ovr, wide, done, viol, pmode;
   wire [2:0]   kind;
   wire [15:0]  sel, off, loc_sel, rdata;
   wire [23:0]  abs_a, phys;
   integer      errors = 0;
   integer      tests_run = 0;
   integer      cycles = 0;
   integer      c, r, i;
   reg  [31:0]  rnd = 32'h00011510; // Seed 70928
   reg  [25:0]  q_acc [$];
   reg  [15:0]  q_reg [$];
   reg  [25:0]  ent;
   reg          rd_seen = 1'b0;
   reg          known = 1'b0;
   reg          ok;
   reg  [23:0]  last = 24'hfffff0;
   // Global entries 0..7: bases and access bytes
   reg  [191:0] bases = {24'h0, 24'h000200, 24'h000100, 24'h400000,
                         24'h300000, 24'h200000, 24'h123400, 24'h0};
   reg  [63:0]  ars = 64'hc4_82_82_b8_9c_90_d0_00;

   always #4 clk_in = ~clk_in;

   seg_translate_protect #(.MAW(10)) DUT (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(rdata), .tbl_wr_in(tbl_wr), .tbl_addr_in(tbl_addr),
      .tbl_wdata_in(tbl_wdata), .translation_select_flag_in(tsf),
      .protection_check_flag_in(pcf), .req_in(req), .req_kind_in(kind),
      .req_sel_in(sel), .req_off_in(off), .req_abs_in(abs_a), .req_loc_ovr_in(ovr),
      .req_loc_sel_in(loc_sel), .req_wide_in(wide), .done_out(done),
      .phys_addr_out(phys), .violation_out(viol), .protect_mode_out(pmode));
   seg_requester u_req (.clk_in(clk_in), .tsf_in(tsf), .pcf_in(pcf), .done_in(done),
      .req_out(req), .kind_out(kind), .sel_out(sel), .off_out(off), .abs_out(abs_a),
      .ovr_out(ovr), .loc_sel_out(loc_sel), .wide_out(wide));
   ////////////////////////////////////////////////////////////////////////////
   function [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Violation expected for kind k, entry e, levels cl and rq
   function viol_of(input [2:0] k, input [2:0] e, input [1:0] cl, input [1:0] rq);
      reg [1:0] d, ef;
      begin
         d = ars[e*8+5 +: 2];
         ef = (rq > cl) ? rq : cl;
         case (k)
            3'h0: viol_of = ars[e*8+3] ? (!ars[e*8+2] && d != cl) : (d < ef);
            3'h1: viol_of = d < ef;
            3'h2: viol_of = d != cl;
            3'h3: viol_of = d < cl || rq > cl;
            default: viol_of = cl > 2'h1;
         endcase
      end
   endfunction
   task check(input [95:0] nm, input [25:0] e, input [25:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge clk_in);
         reg_wr <= 1'b1;
         {reg_addr, reg_wdata} <= {a, d};
         @(posedge clk_in);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [15:0] e);
      begin
         q_reg.push_back(e);
         @(posedge clk_in);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk_in);
         reg_rd <= 1'b0;
      end
   endtask
   // Entry words: limit, base low, rights and base high, spare
   task desc(input [9:0] w, input [23:0] b, input [7:0] a);
      integer n;
      begin
         for (n = 0; n < 4; n = n + 1) begin
            @(posedge clk_in);
            tbl_wr <= 1'b1;
            tbl_addr <= w + n[9:0];
            tbl_wdata <= (n == 0) ? 16'hffff : (n == 1) ? b[15:0] :
                         (n == 2) ? {a, b[23:16]} : 16'h0000;
         end
         @(posedge clk_in);
         tbl_wr <= 1'b0;
      end
   endtask
   // Note the outcome, then issue it
   task acc(input [2:0] k, input [15:0] s, input [15:0] o, input [23:0] a,
            input ov, input [15:0] ls, input v, input cmp, input [23:0] e);
      begin
         q_acc.push_back({v, v ? known : cmp, v ? last : e});
         if (!v) known = cmp;
         if (!v && cmp) last = e;
         u_req.issue(k, s, o, a, ov, ls, k == 3'h5, ok);
         if (!ok) errors = errors + 1;
      end
   endtask
   task pacc(input [2:0] k, input [2:0] e, input [1:0] cl, input [1:0] rq);
      reg [15:0] po;
      reg        v;
      begin
         po = {rnd[15:2], rq};
         v = (pcf && pmode) ? viol_of(k, e, cl, rq) : 1'b0;
         acc(k, {10'h000, e, 1'b0, rq}, po, 24'h0, 1'b0, 16'h0, v, k < 3'h2 && !v,
             bases[e*24 +: 24] + {8'h00, po});
      end
   endtask
   task close_out;
      begin
         if (errors == 0 && tests_run > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Answers come in order of the notes
   always @(negedge clk_in) begin
      if (rd_seen)
         check("reg read", {10'h000, q_reg.pop_front()}, {10'h000, rdata});
      rd_seen = (reg_rd === 1'b1);
      if (done === 1'b1) begin
         ent = q_acc.pop_front();
         check("violation", ent[25], viol);
         if (ent[24])
            check("address", ent[23:0], phys);
      end
   end
   // Hang guard
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         close_out;
      end
   end
   initial begin
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(negedge clk_in);
      check("reset addr", 24'hfffff0, phys);
      check("reset mode", 1'b0, pmode);
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'h3, 16'h0000);
      rd(4'hf, 16'h0000);
      for (i = 0; i < 4; i = i + 1) begin
         rnd = lfsr(rnd);
         acc(3'h0, {1'b0, rnd[30:16]}, rnd[15:0], 24'h0, 1'b0, 16'h0, 1'b0, 1'b1,
             {4'h0, 1'b0, rnd[30:16], 4'h0} + {8'h00, rnd[15:0]});
      end
      rnd = lfsr(rnd);
      acc(3'h5, 16'h0, 16'h0, rnd[23:0], 1'b0, 16'h0, 1'b0, 1'b1, {4'h0, rnd[19:0]});
      for (i = 0; i < 8; i = i + 1)
         desc(i * 4, bases[i*24 +: 24], ars[i*8 +: 8]);
      desc(10'h084, 24'h450000, 8'hf0);
      desc(10'h104, 24'h670000, 8'hf0);
      wr(4'h2, 16'h0000);
      wr(4'h4, 16'h0001);
      wr(4'h0, 16'h0001);
      @(negedge clk_in);
      check("protect mode", 1'b1, pmode);
      @(posedge clk_in);
      tsf <= 1'b1;
      rnd = lfsr(rnd);
      acc(3'h5, 16'h0, 16'h0, rnd[23:0], 1'b0, 16'h0, 1'b0, 1'b1, rnd[23:0]);
      @(posedge clk_in);
      pcf <= 1'b1;
      pacc(3'h0, 3'h1, 2'h0, 2'h0);
      wr(4'h1, 16'h0028);
      rd(4'h1, 16'h0028);
      acc(3'h0, 16'h000f, 16'h0102, 24'h0, 1'b0, 16'h0, 1'b0, 1'b1, 24'h450102);
      acc(3'h0, 16'h000f, 16'h0102, 24'h0, 1'b1, 16'h0030, 1'b0, 1'b1, 24'h670102);
      for (c = 0; c < 4; c = c + 1) begin
         wr(4'h3, c[15:0]);
         for (r = 0; r < 4; r = r + 1) begin
            rnd = lfsr(rnd);
            for (i = 1; i < 5; i = i + 1)
               pacc(3'h0, i[2:0], c[1:0], r[1:0]);
            pacc(3'h1, 3'h1, c[1:0], r[1:0]);
            pacc(3'h2, 3'h4, c[1:0], r[1:0]);
            pacc(3'h3, 3'h7, c[1:0], r[1:0]);
            pacc(3'h4, 3'h0, c[1:0], r[1:0]);
         end
      end
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(negedge clk_in);
      check("reset mode", 1'b0, pmode);
      check("reset addr", 24'hfffff0, phys);
      rd(4'h3, 16'h0000);
      rd(4'h1, 16'h0000);
      repeat (3) @(posedge clk_in);
      close_out;
   end
endmodule // tb
